// ### src/sos_supervisor.sv
// Summary of operation
// - after a reset attempt the outputs fall again if feedback does not show pickup in 300 ms.
// - feedback high means both contactors released; low too long after switch-off blocks restart.
// - feedback wiring present without monitoring enabled puts the block into fault with an error.
// - with the restart interlock on, outputs stay off after an interruption until reset is pressed.
// - while a reset is pending the reset-required output toggles at 1 Hz.
// - high-active diagnostic drives high on contamination or outputs on, else floats.
// - low-active diagnostic floats on contamination or outputs on, else drives high.
// - diagnostic assigned to reset-required pulses at 1 Hz instead of a static level.
// - diagnostic assigned to muting or override ignores polarity and drives high while active.
// - the sender test runs while the test input is low, if the sender test is enabled.
// - safety outputs are high only in the on state with the light path clear, and low on interruption or fault.
//
// Design decisions made here: the address map and register access over Avalon-MM.
`timescale 1ns/1ns
`include "sos_map.svh"
module sos_supervisor #(
   parameter int unsigned EDM_WINDOW_CYC = `SOS_EDM_WINDOW_CYC,
   parameter int unsigned BLINK_HALF_CYC = `SOS_BLINK_HALF_CYC
)
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic irq,
   input wire logic beams_clear,
   input wire logic device_fault,
   input wire logic contactor_feedback,
   input wire logic feedback_wired,
   input wire logic reset_button,
   input wire logic contamination_alarm,
   input wire logic muting_active,
   input wire logic override_active,
   input wire logic sender_test_in_n,
   output logic sender_test_run,
   output logic safety_out_a,
   output logic safety_out_b,
   output logic reset_required_out,
   output logic diag_alarm_out,
   output logic diag_alarm_oe,
   output logic error_indicator
);
   sos_pkg::sos_state_e state_r;
   sos_pkg::sos_state_e state_nxt;
   logic [7:0] ctrl_r;
   logic [`SOS_IRQ_W-1:0] irq_status_r;
   logic [`SOS_IRQ_W-1:0] irq_mask_r;
   logic [`SOS_IRQ_W-1:0] irq_event;
   logic [31:0] readdata_r;
   logic rd_done_r;
   logic [31:0] edm_cnt_r;
   logic edm_fault_r;
   logic cfg_fault_r;
   logic button_prev_r;
   logic safety_a_r;
   logic safety_b_r;
   logic reset_req_r;
   logic diag_out_r;
   logic diag_oe_r;
   logic sender_test_r;
   logic blink;
   logic button_press;
   logic edm_en;
   logic edm_ok;
   logic edm_mismatch;
   logic edm_timeout;
   logic trip;
   logic fault_clear;
   logic wr_ctrl;
   logic wr_irq_status;
   logic wr_irq_mask;
   logic diag_active;
   logic diag_drive;
   sos_pkg::sos_diag_sel_e diag_sel;

   // ---------------- register bus ----------------
   // writes finish at once; reads wait one cycle for registered data
   assign avs_waitrequest = avs_read && !rd_done_r;
   assign wr_ctrl = avs_write && avs_byteenable[0] && avs_address == `SOS_OFS_CTRL;
   assign wr_irq_status = avs_write && avs_byteenable[0] && avs_address == `SOS_OFS_IRQ_STATUS;
   assign wr_irq_mask = avs_write && avs_byteenable[0] && avs_address == `SOS_OFS_IRQ_MASK;
   assign fault_clear = wr_ctrl && avs_writedata[`SOS_CTRL_FAULT_CLEAR];

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         rd_done_r <= 1'b0;
      end
      else
      begin
         rd_done_r <= avs_read && !rd_done_r;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         readdata_r <= 32'h0000_0000;
      end
      else if (avs_read && !rd_done_r)
      begin
         unique case (avs_address)
            `SOS_OFS_CTRL: readdata_r <= {24'h00_0000, 2'b00, ctrl_r[5:0]};
            `SOS_OFS_STATUS: readdata_r <= {24'h00_0000, contactor_feedback, sender_test_r,
               cfg_fault_r, edm_fault_r, state_r == sos_pkg::ST_FAULT,
               state_r == sos_pkg::ST_RESET_WAIT, safety_b_r, safety_a_r};
            `SOS_OFS_IRQ_STATUS: readdata_r <= {28'h000_0000, irq_status_r};
            `SOS_OFS_IRQ_MASK: readdata_r <= {28'h000_0000, irq_mask_r};
            default: readdata_r <= 32'h0000_0000;
         endcase
      end
   end

   assign avs_readdata = readdata_r;

   // fault clear is a command bit and is not stored
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         ctrl_r <= `SOS_CTRL_RESET;
      end
      else if (wr_ctrl)
      begin
         ctrl_r <= {2'b00, avs_writedata[5:0]};
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         irq_mask_r <= `SOS_IRQ_MASK_RESET;
      end
      else if (wr_irq_mask)
      begin
         irq_mask_r <= avs_writedata[`SOS_IRQ_W-1:0];
      end
   end

   // sticky events, write one to clear, a new event wins over the clear
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         irq_status_r <= '0;
      end
      else
      begin
         irq_status_r <= (irq_status_r & ~(wr_irq_status ? avs_writedata[`SOS_IRQ_W-1:0]
            : '0)) | irq_event;
      end
   end

   assign irq = |(irq_status_r & irq_mask_r);

   // ---------------- supervision ----------------
   assign edm_en = ctrl_r[`SOS_CTRL_EDM_EN];
   assign edm_ok = !edm_en || contactor_feedback;
   assign button_press = reset_button && !button_prev_r;
   assign trip = !beams_clear || device_fault;

   // expected feedback: low while outputs on, high while off
   assign edm_mismatch = edm_en && (state_r == sos_pkg::ST_ON ? contactor_feedback
      : (state_r != sos_pkg::ST_FAULT && !contactor_feedback));
   assign edm_timeout = edm_mismatch && edm_cnt_r == 32'(EDM_WINDOW_CYC - 1);

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         button_prev_r <= 1'b0;
      end
      else
      begin
         button_prev_r <= reset_button;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset || !edm_mismatch || state_nxt != state_r)
      begin
         edm_cnt_r <= 32'h0000_0000;
      end
      else
      begin
         edm_cnt_r <= edm_cnt_r + 32'h0000_0001;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         edm_fault_r <= 1'b0;
      end
      else if (edm_timeout)
      begin
         edm_fault_r <= 1'b1;
      end
      else if (fault_clear)
      begin
         edm_fault_r <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         cfg_fault_r <= 1'b0;
      end
      else
      begin
         cfg_fault_r <= feedback_wired && !edm_en;
      end
   end

   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         sos_pkg::ST_OFF:
         begin
            if (cfg_fault_r || edm_timeout)
               state_nxt = sos_pkg::ST_FAULT;
            else if (beams_clear && !device_fault)
            begin
               if (ctrl_r[`SOS_CTRL_INTERLOCK_EN])
                  state_nxt = sos_pkg::ST_RESET_WAIT;
               else if (edm_ok)
                  state_nxt = sos_pkg::ST_ON;
            end
         end
         sos_pkg::ST_RESET_WAIT:
         begin
            if (cfg_fault_r || edm_timeout)
               state_nxt = sos_pkg::ST_FAULT;
            else if (trip)
               state_nxt = sos_pkg::ST_OFF;
            else if (button_press && edm_ok)
               state_nxt = sos_pkg::ST_ON;
         end
         sos_pkg::ST_ON:
         begin
            if (cfg_fault_r || edm_timeout)
               state_nxt = sos_pkg::ST_FAULT;
            else if (trip)
               state_nxt = sos_pkg::ST_OFF;
         end
         sos_pkg::ST_FAULT:
         begin
            if (fault_clear && !cfg_fault_r && !device_fault)
               state_nxt = sos_pkg::ST_OFF;
         end
         default:
         begin
            state_nxt = sos_pkg::ST_FAULT;
         end
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         state_r <= sos_pkg::ST_OFF;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   // each channel has its own flip-flop and its own decode
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         safety_a_r <= 1'b0;
      end
      else
      begin
         safety_a_r <= state_nxt == sos_pkg::ST_ON && beams_clear;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         safety_b_r <= 1'b0;
      end
      else
      begin
         safety_b_r <= state_nxt[2] && !device_fault;
      end
   end

   assign irq_event[`SOS_IRQ_TRIP] = state_r == sos_pkg::ST_ON && state_nxt != sos_pkg::ST_ON;
   assign irq_event[`SOS_IRQ_EDM_FAULT] = edm_timeout;
   assign irq_event[`SOS_IRQ_CFG_FAULT] = feedback_wired && !edm_en && !cfg_fault_r;
   assign irq_event[`SOS_IRQ_RESET_PEND] = state_nxt == sos_pkg::ST_RESET_WAIT
      && state_r != sos_pkg::ST_RESET_WAIT;

   // ---------------- indicators ----------------
   sos_blink #(
      .HALF_CYC(BLINK_HALF_CYC)
   ) u_blink (
      .ref_clk(ref_clk),
      .reset(reset),
      .run(state_r == sos_pkg::ST_RESET_WAIT),
      .wave(blink)
   );

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         reset_req_r <= 1'b0;
      end
      else
      begin
         // dark as soon as the pending reset ends, so the lamp never shows with outputs on
         reset_req_r <= blink && state_nxt == sos_pkg::ST_RESET_WAIT;
      end
   end

   assign diag_sel = sos_pkg::sos_diag_sel_e'(ctrl_r[`SOS_CTRL_DIAG_SEL_HI:`SOS_CTRL_DIAG_SEL_LO]);
   assign diag_active = contamination_alarm || safety_a_r || safety_b_r;

   always_comb
   begin
      diag_drive = 1'b0;
      unique case (diag_sel)
         sos_pkg::DIAG_OUTPUT_STATE:
         begin
            if (ctrl_r[`SOS_CTRL_DIAG_POL_LOW])
               diag_drive = !diag_active;
            else
               diag_drive = diag_active;
         end
         sos_pkg::DIAG_RESET_REQUIRED: diag_drive = blink;
         sos_pkg::DIAG_MUTING: diag_drive = muting_active || override_active;
         sos_pkg::DIAG_NONE: diag_drive = 1'b0;
      endcase
   end

   // the pin is either driven high or left floating
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         diag_out_r <= 1'b0;
         diag_oe_r <= 1'b0;
      end
      else
      begin
         diag_out_r <= diag_drive;
         diag_oe_r <= diag_drive;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         sender_test_r <= 1'b0;
      end
      else
      begin
         sender_test_r <= ctrl_r[`SOS_CTRL_SENDER_TEST_EN] && !sender_test_in_n;
      end
   end

   assign sender_test_run = sender_test_r;
   assign safety_out_a = safety_a_r;
   assign safety_out_b = safety_b_r;
   assign reset_required_out = reset_req_r;
   assign diag_alarm_out = diag_out_r;
   assign diag_alarm_oe = diag_oe_r;
   assign error_indicator = state_r == sos_pkg::ST_FAULT;
endmodule // sos_supervisor

// ### src/sos_map.svh
`ifndef SOS_MAP_SVH
`define SOS_MAP_SVH

// clock and timing
`define SOS_CLK_HZ 50000000
`define SOS_EDM_WINDOW_MS 300
`define SOS_EDM_WINDOW_CYC ((`SOS_CLK_HZ / 1000) * `SOS_EDM_WINDOW_MS)
`define SOS_BLINK_HZ 1
`define SOS_BLINK_HALF_CYC (`SOS_CLK_HZ / (2 * `SOS_BLINK_HZ))

// register byte offsets
`define SOS_OFS_CTRL 8'h00
`define SOS_OFS_STATUS 8'h04
`define SOS_OFS_IRQ_STATUS 8'h08
`define SOS_OFS_IRQ_MASK 8'h0C

// control fields
`define SOS_CTRL_EDM_EN 0
`define SOS_CTRL_INTERLOCK_EN 1
`define SOS_CTRL_SENDER_TEST_EN 2
`define SOS_CTRL_DIAG_POL_LOW 3
`define SOS_CTRL_DIAG_SEL_LO 4
`define SOS_CTRL_DIAG_SEL_HI 5
`define SOS_CTRL_FAULT_CLEAR 6
`define SOS_CTRL_RESET 8'h02

// status fields
`define SOS_STAT_OUT_A 0
`define SOS_STAT_OUT_B 1
`define SOS_STAT_RESET_PEND 2
`define SOS_STAT_FAULT 3
`define SOS_STAT_EDM_FAULT 4
`define SOS_STAT_CFG_FAULT 5
`define SOS_STAT_SENDER_TEST 6
`define SOS_STAT_FEEDBACK 7

// interrupt event bits
`define SOS_IRQ_TRIP 0
`define SOS_IRQ_EDM_FAULT 1
`define SOS_IRQ_CFG_FAULT 2
`define SOS_IRQ_RESET_PEND 3
`define SOS_IRQ_W 4
`define SOS_IRQ_MASK_RESET 4'h0

`endif

// ### src/sos_pkg.sv
package sos_pkg;

   typedef enum logic [3:0]
   {
      ST_OFF = 4'b0001,
      ST_RESET_WAIT = 4'b0010,
      ST_ON = 4'b0100,
      ST_FAULT = 4'b1000
   } sos_state_e;

   typedef enum logic [1:0]
   {
      DIAG_OUTPUT_STATE = 2'b00,
      DIAG_RESET_REQUIRED = 2'b01,
      DIAG_MUTING = 2'b10,
      DIAG_NONE = 2'b11
   } sos_diag_sel_e;

endpackage

// ### src/sos_blink.sv
`timescale 1ns/1ns
module sos_blink #(
   parameter int unsigned HALF_CYC = 25000000
)
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic run,
   output logic wave
);
   logic [31:0] cnt_r;
   logic wave_r;

   // square wave starting high when run rises, idle low
   always_ff @(posedge ref_clk)
   begin
      if (reset || !run)
      begin
         cnt_r <= 32'(HALF_CYC - 1);
         wave_r <= 1'b0;
      end
      else if (cnt_r == 32'(HALF_CYC - 1))
      begin
         cnt_r <= 32'h0000_0000;
         wave_r <= !wave_r;
      end
      else
      begin
         cnt_r <= cnt_r + 32'h0000_0001;
      end
   end

   assign wave = wave_r;
endmodule // sos_blink

// ### test/sos_supervisor_sva.sv
`timescale 1ns/1ns
module sos_supervisor_sva (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic beams_clear,
   input wire logic device_fault,
   input wire logic sender_test_in_n,
   input wire logic sender_test_run,
   input wire logic safety_out_a,
   input wire logic safety_out_b,
   input wire logic reset_required_out,
   input wire logic diag_alarm_out,
   input wire logic diag_alarm_oe,
   input wire logic error_indicator
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);
   sequence s_ack;
      avs_waitrequest ##1 !avs_waitrequest;
   endsequence
   // high phase of the blinker, four cycles at the bench setting
   sequence s_hi4;
      $rose(reset_required_out) ##1 reset_required_out [*3];
   endsequence
   property p_rd;
      $rose(avs_read) |-> s_ack;
   endproperty
   a_rd: assert property (p_rd) else $error("read wait cycle wrong");
   property p_wr;
      avs_write |-> !avs_waitrequest;
   endproperty
   a_wr: assert property (p_wr) else $error("write stalled");
   property p_trip;
      !beams_clear || device_fault |=> !safety_out_a && !safety_out_b;
   endproperty
   a_trip: assert property (p_trip) else $error("outputs stayed on");
   property p_on;
      $rose(safety_out_a) |-> $past(beams_clear) && !$past(device_fault);
   endproperty
   a_on: assert property (p_on) else $error("outputs on without cause");
   property p_pair;
      safety_out_a == safety_out_b;
   endproperty
   a_pair: assert property (p_pair) else $error("channels differ");
   property p_err;
      error_indicator |-> !safety_out_a && !safety_out_b;
   endproperty
   a_err: assert property (p_err) else $error("outputs on in fault");
   property p_rr;
      s_hi4 |=> !reset_required_out;
   endproperty
   a_rr: assert property (p_rr) else $error("blink half period wrong");
   property p_rr_off;
      reset_required_out |-> !safety_out_a;
   endproperty
   a_rr_off: assert property (p_rr_off) else $error("blink while on");
   property p_oe;
      diag_alarm_out == diag_alarm_oe;
   endproperty
   a_oe: assert property (p_oe) else $error("diag drive mismatch");
   property p_st;
      sender_test_run |-> !$past(sender_test_in_n);
   endproperty
   a_st: assert property (p_st) else $error("sender test without request");
endmodule // sos_supervisor_sva

// ### test/sos_plant.sv
`timescale 1ns/1ns
module sos_plant (
   input wire logic ref_clk,
   input wire logic safety_out_a,
   input wire logic safety_out_b,
   input wire logic [1:0] mode,
   output logic contactor_feedback
);
   logic [1:0] rel_a_r;
   logic [1:0] rel_b_r;
   // each contactor releases two cycles after its own channel drops
   always @(posedge ref_clk)
   begin
      rel_a_r <= {rel_a_r[0], !safety_out_a};
      rel_b_r <= {rel_b_r[0], !safety_out_b};
   end
   // mode 1: never picks up, mode 2: one contact welded shut
   assign contactor_feedback = (mode == 2'h1) | ((mode != 2'h2) & rel_a_r[1] & rel_b_r[1]);
endmodule // sos_plant

// ### test/tb_top.sv
`timescale 1ns/1ns
`include "sos_map.svh"
`define CHK(n, g, e) \
   begin \
      num_checks++; \
      if ((g) !== (e)) \
      begin \
         n_mismatch++; \
         $display("[FAIL] %s exp %h seen %h", n, e, g); \
      end \
   end
module tb_top;
   logic ref_clk = 0, reset = 1, avs_read = 0, avs_write = 0, probe = 0, x;
   logic [7:0] avs_address = 0;
   logic [31:0] avs_writedata = 0, avs_readdata, g, r;
   logic avs_waitrequest, irq, sender_test_run, safety_out_a, safety_out_b;
   logic reset_required_out, diag_alarm_out, diag_alarm_oe, error_indicator;
   logic beams_clear = 1, device_fault = 0, feedback_wired = 0, reset_button = 0;
   logic contamination_alarm = 0, muting_active = 0, override_active = 0;
   logic sender_test_in_n = 1, contactor_feedback;
   logic [1:0] mode = 0;
   logic [63:0] q[$];
   logic [63:0] e;
   int n_mismatch = 0;
   int num_checks = 0;
   always #10 ref_clk = !ref_clk;
   sos_supervisor #(.EDM_WINDOW_CYC(8), .BLINK_HALF_CYC(4)) sos_supervisor_inst (
      .ref_clk(ref_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
      .beams_clear(beams_clear), .device_fault(device_fault),
      .contactor_feedback(contactor_feedback), .feedback_wired(feedback_wired),
      .reset_button(reset_button), .contamination_alarm(contamination_alarm),
      .muting_active(muting_active), .override_active(override_active),
      .sender_test_in_n(sender_test_in_n), .sender_test_run(sender_test_run),
      .safety_out_a(safety_out_a), .safety_out_b(safety_out_b),
      .reset_required_out(reset_required_out), .diag_alarm_out(diag_alarm_out),
      .diag_alarm_oe(diag_alarm_oe), .error_indicator(error_indicator));
   sos_plant sos_plant_inst (.ref_clk(ref_clk), .safety_out_a(safety_out_a),
      .safety_out_b(safety_out_b), .mode(mode), .contactor_feedback(contactor_feedback));
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic xfer(input logic is_rd, input logic [7:0] a, input logic [31:0] d);
      int i;
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= is_rd;
      avs_write <= !is_rd;
      i = 0;
      do
      begin
         @(posedge ref_clk);
         i++;
      end
      while (avs_waitrequest !== 1'b0 && i < 20);
      avs_read <= 0;
      avs_write <= 0;
      if (avs_waitrequest !== 1'b0)
      begin
         n_mismatch++;
         close_out();
      end
      @(posedge ref_clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
      q.push_back({m, v});
      xfer(1'b1, a, 32'h0);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b0, a, d);
   endtask
   task automatic pin(input logic [7:0] m, input logic [7:0] v);
      q.push_back({24'h0, m, 24'h0, v});
      probe <= 1;
      @(posedge ref_clk);
      probe <= 0;
      @(posedge ref_clk);
   endtask
   task automatic press();
      reset_button <= 1;
      @(posedge ref_clk);
      reset_button <= 0;
      cyc(4);
   endtask
   task automatic trip();
      beams_clear <= 0;
      @(posedge ref_clk);
      beams_clear <= 1;
   endtask
   // pins word: out b, out a, diag level, reset lamp, error, irq, diag drive, sender test
   always @(posedge ref_clk)
   begin
      if ((avs_read === 1'b1 && avs_waitrequest === 1'b0) || probe)
      begin
         e = q.pop_front();
         g = probe ? {24'h0, safety_out_b, safety_out_a, diag_alarm_out, reset_required_out,
            error_indicator, irq, diag_alarm_oe, sender_test_run} : avs_readdata;
         `CHK(probe ? "pins" : "readdata", e[63:32] & g, e[31:0])
      end
   end
   initial
   begin
      cyc(12);
      reset <= 0;
      @(posedge ref_clk);
      void'($urandom(69480));
      rd(`SOS_OFS_CTRL, 32'hFF, `SOS_CTRL_RESET);
      rd(`SOS_OFS_IRQ_MASK, 32'hF, 32'h0);
      rd(8'h40, 32'hFFFF_FFFF, 32'h0);
      rd(`SOS_OFS_STATUS, 32'hF, 32'h4);
      press();
      rd(`SOS_OFS_STATUS, 32'hF, 32'h3);
      $display("test restart done");
      trip();
      cyc(3);
      rd(`SOS_OFS_STATUS, 32'h7, 32'h4);
      pin(8'h04, 8'h00);
      wr(`SOS_OFS_IRQ_MASK, 32'h1);
      pin(8'h04, 8'h04);
      wr(`SOS_OFS_IRQ_STATUS, 32'hF);
      pin(8'h04, 8'h00);
      rd(`SOS_OFS_IRQ_STATUS, 32'h1, 32'h0);
      wr(`SOS_OFS_IRQ_MASK, 32'h0);
      $display("test trip_irq done");
      wr(`SOS_OFS_CTRL, 32'h3);
      mode <= 2'h1;
      press();
      cyc(10);
      rd(`SOS_OFS_STATUS, 32'h1B, 32'h18);
      mode <= 2'h0;
      wr(`SOS_OFS_CTRL, 32'h43);
      cyc(4);
      rd(`SOS_OFS_STATUS, 32'h1F, 32'h4);
      press();
      rd(`SOS_OFS_STATUS, 32'h3, 32'h3);
      mode <= 2'h2;
      trip();
      cyc(14);
      rd(`SOS_OFS_STATUS, 32'h1B, 32'h18);
      mode <= 2'h0;
      wr(`SOS_OFS_CTRL, 32'h43);
      cyc(4);
      $display("test feedback done");
      wr(`SOS_OFS_CTRL, 32'h2);
      feedback_wired <= 1;
      cyc(4);
      rd(`SOS_OFS_STATUS, 32'h28, 32'h28);
      pin(8'h08, 8'h08);
      feedback_wired <= 0;
      cyc(2);
      wr(`SOS_OFS_CTRL, 32'h42);
      cyc(4);
      $display("test config_fault done");
      repeat (12)
      begin
         r = $urandom;
         if (r[5:4] == 2'h1)
            r[5:4] = 2'h3;
         contamination_alarm <= r[8];
         muting_active <= r[9];
         override_active <= r[10];
         sender_test_in_n <= r[11];
         wr(`SOS_OFS_CTRL, {26'h0, r[5:2], 2'h2});
         cyc(2);
         x = (r[5:4] == 2'h0) ? r[8] ^ r[3] : (r[5:4] == 2'h2) ? r[9] | r[10] : 1'b0;
         pin(8'h23, {2'h0, x, 3'h0, x, r[2] & !r[11]});
         rd(`SOS_OFS_STATUS, 32'h40, {25'h0, r[2] & !r[11], 6'h0});
      end
      $display("test diag done");
      // re-enter the pending reset so the lamp phase is known; half period four cycles here
      wr(`SOS_OFS_CTRL, 32'h12);
      trip();
      cyc(2);
      for (int j = 3; j < 15; j += 2)
         pin(8'hD2, ((j + 4) % 8) < 4 ? 8'h12 : 8'h00);
      $display("test blink done");
      wr(`SOS_OFS_CTRL, 32'h2);
      press();
      rd(`SOS_OFS_STATUS, 32'h3, 32'h3);
      device_fault <= 1;
      cyc(3);
      rd(`SOS_OFS_STATUS, 32'hF, 32'h0);
      device_fault <= 0;
      $display("test device_fault done");
      close_out();
   end
endmodule // tb_top
bind sos_supervisor sos_supervisor_sva sos_supervisor_sva_inst (.ref_clk(ref_clk),
   .reset(reset), .avs_read(avs_read), .avs_write(avs_write),
   .avs_waitrequest(avs_waitrequest), .beams_clear(beams_clear),
   .device_fault(device_fault), .sender_test_in_n(sender_test_in_n),
   .sender_test_run(sender_test_run), .safety_out_a(safety_out_a),
   .safety_out_b(safety_out_b), .reset_required_out(reset_required_out),
   .diag_alarm_out(diag_alarm_out), .diag_alarm_oe(diag_alarm_oe),
   .error_indicator(error_indicator));
